// >>> core/_unused.sv
`default_nettype none
`default_nettype wire

// >>> core/sfp_pin_if.sv
// pin-level serial interface of a serial flash: shifting, select, pause, write guard
// assumes clk runs well above the host serial clock; all pins are asynchronous to clk
`default_nettype none
module sfp_pin_if (
	// system
	input  wire logic                        clk,
	input  wire logic                        rst,
	// device pins
	input  wire logic                        sck,
	input  wire logic                        si,
	input  wire logic                        cs_n,
	input  wire logic                        hold_n,
	input  wire logic                        wp_n,
	output logic                             so,
	output logic                             so_oe,
	// received bytes
	output logic [sfp_pkg::BYTE_W-1:0]       rx_byte,
	output logic                             rx_valid,
	output logic                             rx_first,
	// byte to send, sampled at each byte boundary
	input  wire logic [sfp_pkg::BYTE_W-1:0]  tx_byte,
	// array write guard
	input  wire logic                        wr_req,
	input  wire logic [sfp_pkg::ADDR_W-1:0]  wr_addr,
	input  wire logic [sfp_pkg::BP_W-1:0]    block_protect_bits,
	output logic                             wr_grant,
	output logic                             wr_block,
	// power state
	input  wire logic                        op_busy,
	output logic                             standby
);
	// =====================================================
	// pin synchronisers
	logic [sfp_pkg::PIN_W-1:0] pin_meta;
	logic [sfp_pkg::PIN_W-1:0] pin_sync;
	logic                      sck_q;
	logic                      cs_q;
	logic                      hold_q;

	// edge detectors read only the second stage, never the metastable first one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta <= sfp_pkg::PIN_RST;
			pin_sync <= sfp_pkg::PIN_RST;
			sck_q    <= sfp_pkg::PIN_RST[sfp_pkg::PIN_SCK];
			cs_q     <= sfp_pkg::PIN_RST[sfp_pkg::PIN_CS_N];
			hold_q   <= sfp_pkg::PIN_RST[sfp_pkg::PIN_HOLD_N];
		end else begin
			pin_meta <= {wp_n, hold_n, cs_n, si, sck};
			pin_sync <= pin_meta;
			sck_q    <= pin_sync[sfp_pkg::PIN_SCK];
			cs_q     <= pin_sync[sfp_pkg::PIN_CS_N];
			hold_q   <= pin_sync[sfp_pkg::PIN_HOLD_N];
		end
	end

	wire logic s_sck, s_si, s_cs_n, s_hold_n, s_wp_n;
	wire logic sck_rise, sck_fall, cs_fall, hold_fall, hold_rise;

	assign s_sck     = pin_sync[sfp_pkg::PIN_SCK];
	assign s_si      = pin_sync[sfp_pkg::PIN_SI];
	assign s_cs_n    = pin_sync[sfp_pkg::PIN_CS_N];
	assign s_hold_n  = pin_sync[sfp_pkg::PIN_HOLD_N];
	assign s_wp_n    = pin_sync[sfp_pkg::PIN_WP_N];
	assign sck_rise  = s_sck && !sck_q;
	assign sck_fall  = !s_sck && sck_q;
	assign cs_fall   = !s_cs_n && cs_q;
	assign hold_fall = !s_hold_n && hold_q;
	assign hold_rise = s_hold_n && !hold_q;

	// =====================================================
	// arming and selection
	// a device that powers up with cs_n already low arms once the synchroniser fills, since reset loads cs_n high
	logic armed;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			armed <= 1'b0;
		else if (cs_fall)
			armed <= 1'b1;
	end

	wire logic sel;
	assign sel = armed && !s_cs_n;

	// =====================================================
	// pause tracking
	logic paused, pend_in, pend_out;
	wire logic next_paused;
	wire logic next_pend_in;
	wire logic next_pend_out;
	wire logic enter_now;
	wire logic leave_now;

	// a clock-high edge of the pause pin is deferred to the next clock fall
	assign enter_now = (hold_fall && !s_sck) || (pend_in && sck_fall && !s_hold_n);
	assign leave_now = (hold_rise && !s_sck) || (pend_out && sck_fall && s_hold_n);
	assign next_paused   = s_cs_n ? 1'b0 : (paused ? !leave_now : enter_now);
	assign next_pend_in  = !s_cs_n && !paused && !enter_now && !s_hold_n &&
	                       (pend_in || (hold_fall && s_sck));
	assign next_pend_out = !s_cs_n && paused && !leave_now && s_hold_n &&
	                       (pend_out || (hold_rise && s_sck));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			paused   <= 1'b0;
			pend_in  <= 1'b0;
			pend_out <= 1'b0;
		end else begin
			paused   <= next_paused;
			pend_in  <= next_pend_in;
			pend_out <= next_pend_out;
		end
	end

	// serial clock and input count only while selected and not pausing
	wire logic act;
	assign act = sel && !paused && !next_paused;

	// =====================================================
	// receive shifter
	logic [sfp_pkg::BIT_CNT_W-1:0] bit_cnt;
	logic [sfp_pkg::BYTE_W-1:0]    rx_sh;
	logic                          first_byte;
	wire logic                     shift_in;
	wire logic                     byte_done;
	wire logic [sfp_pkg::BYTE_W-1:0] next_rx;

	assign shift_in  = act && sck_rise;
	assign byte_done = shift_in && (bit_cnt == sfp_pkg::BIT_LAST);
	assign next_rx   = {rx_sh[sfp_pkg::BYTE_W-2:0], s_si};

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bit_cnt    <= sfp_pkg::BIT_FIRST;
			rx_sh      <= sfp_pkg::BYTE_RST;
			first_byte <= 1'b0;
		end else if (s_cs_n) begin
			bit_cnt    <= sfp_pkg::BIT_FIRST;
			first_byte <= 1'b1;
		end else if (shift_in) begin
			bit_cnt    <= bit_cnt + sfp_pkg::BIT_STEP;
			rx_sh      <= next_rx;
			if (byte_done)
				first_byte <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_byte  <= sfp_pkg::BYTE_RST;
			rx_valid <= 1'b0;
			rx_first <= 1'b0;
		end else begin
			rx_valid <= byte_done;
			if (byte_done) begin
				rx_byte  <= next_rx;
				rx_first <= first_byte;
			end
		end
	end

	// =====================================================
	// transmit shifter
	// tx_byte must be stable from rx_valid until the next clock fall
	logic [sfp_pkg::BYTE_W-1:0] tx_sh;
	wire logic                  shift_out;
	wire logic                  load_tx;

	assign shift_out = act && sck_fall;
	assign load_tx   = (cs_fall && armed) || (shift_out && (bit_cnt == sfp_pkg::BIT_FIRST));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			so    <= 1'b0;
			tx_sh <= sfp_pkg::BYTE_RST;
		end else if (load_tx || cs_fall) begin
			so    <= tx_byte[sfp_pkg::BYTE_W-1];
			tx_sh <= {tx_byte[sfp_pkg::BYTE_W-2:0], 1'b0};
		end else if (shift_out) begin
			so    <= tx_sh[sfp_pkg::BYTE_W-1];
			tx_sh <= {tx_sh[sfp_pkg::BYTE_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			so_oe <= 1'b0;
		else
			so_oe <= sel && !next_paused;
	end

	// =====================================================
	// write guard and power state
	wire logic in_region;
	wire logic guard_hit;

	sfp_protect u_protect (
		.block_protect_bits (block_protect_bits),
		.addr               (wr_addr),
		.in_region          (in_region)
	);

	assign guard_hit = !s_wp_n && in_region;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_grant <= 1'b0;
			wr_block <= 1'b0;
			standby  <= 1'b1;
		end else begin
			wr_grant <= wr_req && !guard_hit;
			wr_block <= wr_req && guard_hit;
			standby  <= s_cs_n && !op_busy;
		end
	end

	// =====================================================
	// checks
	property p_oe_off_deselect;
		@(posedge clk) disable iff (rst) s_cs_n |=> !so_oe;
	endproperty
	a_oe_off_deselect: assert property (p_oe_off_deselect)
		else $error("output enabled while deselected");

	property p_oe_off_pause;
		@(posedge clk) disable iff (rst) paused |-> !so_oe;
	endproperty
	a_oe_off_pause: assert property (p_oe_off_pause)
		else $error("output enabled while paused");

	property p_rx_sample;
		@(posedge clk) disable iff (rst)
			(act && sck_rise && bit_cnt == 3'h7) |=> (rx_valid && rx_byte[0] == $past(s_si));
	endproperty
	a_rx_sample: assert property (p_rx_sample)
		else $error("byte not taken on rising clock");

	property p_tx_shift;
		@(posedge clk) disable iff (rst)
			(shift_out && bit_cnt != 3'h0 && !cs_fall) |=> (so == $past(tx_sh[7]));
	endproperty
	a_tx_shift: assert property (p_tx_shift)
		else $error("output bit not driven on falling clock");

	property p_unarmed_quiet;
		@(posedge clk) disable iff (rst) !armed |=> !rx_valid;
	endproperty
	a_unarmed_quiet: assert property (p_unarmed_quiet)
		else $error("byte accepted before first select fall");

	property p_busy_active;
		@(posedge clk) disable iff (rst) (op_busy || !s_cs_n) |=> !standby;
	endproperty
	a_busy_active: assert property (p_busy_active)
		else $error("standby while selected or busy");

	property p_guard;
		@(posedge clk) disable iff (rst)
			(wr_req && !s_wp_n && in_region) |=> (wr_block && !wr_grant);
	endproperty
	a_guard: assert property (p_guard)
		else $error("protected write not blocked");

	property p_pause_enter;
		@(posedge clk) disable iff (rst)
			(hold_fall && !s_sck && !s_cs_n) |=> paused ##1 !so_oe;
	endproperty
	a_pause_enter: assert property (p_pause_enter)
		else $error("pause not begun at pause fall");

	property p_pause_leave;
		@(posedge clk) disable iff (rst)
			(hold_rise && !s_sck && paused && !s_cs_n) |=> !paused;
	endproperty
	a_pause_leave: assert property (p_pause_leave)
		else $error("pause not ended at pause rise");

	property p_count_clear;
		@(posedge clk) disable iff (rst) s_cs_n |=> (bit_cnt == 3'h0);
	endproperty
	a_count_clear: assert property (p_count_clear)
		else $error("bit count not cleared on deselect");

	c_byte:   cover property (@(posedge clk) disable iff (rst) rx_valid && rx_first);
	c_pause:  cover property (@(posedge clk) disable iff (rst) pend_in ##[1:40] paused);
	c_block:  cover property (@(posedge clk) disable iff (rst) wr_block);
endmodule : sfp_pin_if
`default_nettype wire

// >>> core/sfp_pkg.sv
// constants shared by the serial flash pin interface and its protect decoder
// assumes a single system clock that oversamples the host serial clock
`default_nettype none
package sfp_pkg;
	// =====================================================
	// serial framing
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned BIT_CNT_W = 3;
	localparam logic [2:0]  BIT_FIRST = 3'h0;
	localparam logic [2:0]  BIT_LAST  = 3'h7;
	localparam logic [2:0]  BIT_STEP  = 3'h1;

	// =====================================================
	// pin synchroniser order {wp_n, hold_n, cs_n, si, sck}
	localparam int unsigned PIN_W      = 5;
	localparam int unsigned PIN_SCK    = 0;
	localparam int unsigned PIN_SI     = 1;
	localparam int unsigned PIN_CS_N   = 2;
	localparam int unsigned PIN_HOLD_N = 3;
	localparam int unsigned PIN_WP_N   = 4;
	localparam logic [4:0]  PIN_RST    = 5'h1e;

	// =====================================================
	// array geometry: 32 sectors of 64 KiB
	localparam int unsigned ADDR_W     = 21;
	localparam int unsigned SECT_LSB   = 16;
	localparam int unsigned SECT_W     = 5;
	localparam int unsigned BP_W       = 3;
	localparam logic [4:0]  SECT_ALL   = 5'h1f;

	// =====================================================
	// reset values
	localparam logic [7:0]  BYTE_RST   = 8'h00;
endpackage : sfp_pkg
`default_nettype wire

// >>> core/sfp_protect.sv
// decodes whether an array address lies in the region named by block_protect_bits
// assumes the address is a byte address into a 2 MiB array
`default_nettype none
module sfp_protect (
	// protect setting
	input  wire logic [sfp_pkg::BP_W-1:0]   block_protect_bits,
	// address under test
	input  wire logic [sfp_pkg::ADDR_W-1:0] addr,
	// result
	output wire logic                       in_region
);
	// =====================================================
	// top-of-array region: the upper sectors whose index has the masked bits set
	wire logic [sfp_pkg::SECT_W-1:0] sector;
	wire logic [sfp_pkg::SECT_W-1:0] mask;
	wire logic                       whole;
	wire logic                       none;

	assign sector = addr[sfp_pkg::ADDR_W-1:sfp_pkg::SECT_LSB];
	assign mask   = (block_protect_bits == 3'h1) ? 5'h1f :
	                (block_protect_bits == 3'h2) ? 5'h1e :
	                (block_protect_bits == 3'h3) ? 5'h1c :
	                (block_protect_bits == 3'h4) ? 5'h18 : 5'h10;
	assign whole  = (block_protect_bits == 3'h6) || (block_protect_bits == 3'h7);
	assign none   = (block_protect_bits == 3'h0);
	assign in_region = !none && (whole || ((sector & mask) == mask));
endmodule : sfp_protect
`default_nettype wire

// >>> testbench/sfp_host_model.sv
// host-side bus master model driving the serial flash pins
// assumes the bench calls one task at a time; all delays are in ns
`default_nettype none
module sfp_host_model (
	// device pins
	output logic      sck,
	output logic      si,
	output logic      cs_n,
	output logic      hold_n,
	input  wire logic so,
	input  wire logic so_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic so_last;
	wire  so_w;

	// =====================================================
	// a floated output reads as the inverse of its last value, so no lucky match
	always @(so or so_oe) if (so_oe) so_last = so;
	assign so_w = so_oe ? so : ~so_last;

	initial begin
		sck = 1'b0;
		si = 1'b0;
		cs_n = 1'b1;
		hold_n = 1'b1;
	end

	// =====================================================
	// framing
	task automatic start(input bit m3);
		sck = m3;
		#400 cs_n = 1'b0;
		#400;
	endtask : start

	task automatic xbyte(input logic [7:0] d, input int nb, output logic [7:0] q);
		q = 8'h00;
		for (int i = 0; i < nb; i++) begin
			si = d[7 - i];
			sck = 1'b0;
			#200 sck = 1'b1;
			#190 q = {q[6:0], so_w};
			#10;
		end
	endtask : xbyte

	task automatic stop(input bit m3);
		#200 sck = m3;
		#200 cs_n = 1'b1;
		si = ~si;
		#400;
	endtask : stop

	// pause is only used while selected, with the clock parked low
	task automatic hold_mid(input bit v);
		sck = 1'b0;
		#100 hold_n = v;
		#300;
	endtask : hold_mid
endmodule : sfp_host_model
`default_nettype wire

// >>> testbench/sfp_pin_if_tb_top.sv
// self-checking bench for the serial flash pin interface
// assumes the host model owns the serial pins; the bench owns the array-side ports
`default_nettype none
module sfp_pin_if_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic                       clk, rst, wp_n, wr_req, op_busy;
	logic [sfp_pkg::ADDR_W-1:0] wr_addr;
	logic [sfp_pkg::BP_W-1:0]   bp;
	wire logic                  sck, si, cs_n, hold_n, so, so_oe;
	wire logic                  rx_valid, rx_first, wr_grant, wr_block, standby;
	wire logic [7:0]            rx_byte, tx_byte;
	logic [7:0]                 txt [4];
	logic [7:0]                 hs [4];
	logic [1:0]                 txn;
	logic [7:0]                 rxq [$];
	logic                       fq [$];
	int                         num_errors, checked;

	sfp_host_model u_host (.sck(sck), .si(si), .cs_n(cs_n), .hold_n(hold_n),
		.so(so), .so_oe(so_oe));
	sfp_pin_if u_dut (.clk(clk), .rst(rst), .sck(sck), .si(si), .cs_n(cs_n),
		.hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_first(rx_first), .tx_byte(tx_byte), .wr_req(wr_req),
		.wr_addr(wr_addr), .block_protect_bits(bp), .wr_grant(wr_grant),
		.wr_block(wr_block), .op_busy(op_busy), .standby(standby));

	// =====================================================
	// array-side feed and capture
	assign tx_byte = txt[txn];
	always #25 clk = ~clk;
	always @(posedge clk or posedge rst) begin
		if (rst) txn <= 2'h0;
		else if (cs_n) txn <= 2'h0;
		else if (rx_valid === 1'b1) txn <= txn + 2'h1;
	end
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			rxq.push_back(rx_byte);
			fq.push_back(rx_first);
		end
	end

	// =====================================================
	// checking
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp, input string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %b exp %b", $time, m, got, exp);
		end
	endtask : chk_bit

	task automatic conclude();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// =====================================================
	// scenarios
	task automatic frame_test(input bit m3, input int n);
		logic [7:0] q;
		rxq.delete();
		fq.delete();
		u_host.start(m3);
		chk_bit(so_oe, 1'b1, "oe selected");
		chk_bit(standby, 1'b0, "standby selected");
		for (int b = 0; b < n; b++) begin
			u_host.xbyte(hs[b], 8, q);
			chk_byte(q, txt[b], "so byte");
		end
		// a trailing partial byte must not spill into the next frame
		if (m3) u_host.xbyte(8'hff, 4, q);
		u_host.stop(m3);
		chk_bit(so_oe, 1'b0, "oe deselected");
		chk_byte(8'(rxq.size()), 8'(n), "rx count");
		for (int b = 0; b < n; b++) begin
			chk_byte(rxq[b], hs[b], "rx byte");
			chk_bit(fq[b], b == 0, "first flag");
		end
	endtask : frame_test

	task automatic standby_test();
		logic [7:0] q;
		rxq.delete();
		@(posedge clk) #2 op_busy = 1'b1;
		u_host.start(1'b0);
		u_host.stop(1'b0);
		chk_bit(standby, 1'b0, "standby busy");
		u_host.xbyte(hs[0], 8, q);
		u_host.stop(1'b0);
		chk_byte(8'(rxq.size()), 8'h00, "rx deselected");
		@(posedge clk) #2 op_busy = 1'b0;
		repeat (4) @(posedge clk);
		chk_bit(standby, 1'b1, "standby idle");
	endtask : standby_test

	task automatic pause_test();
		logic [7:0] q;
		rxq.delete();
		u_host.start(1'b0);
		u_host.xbyte(hs[1], 4, q);
		u_host.hold_mid(1'b0);
		chk_bit(so_oe, 1'b0, "oe paused");
		u_host.xbyte(8'h00, 8, q);
		u_host.hold_mid(1'b1);
		chk_bit(so_oe, 1'b1, "oe resumed");
		u_host.xbyte({hs[1][3:0], 4'h0}, 4, q);
		u_host.stop(1'b0);
		chk_byte(8'(rxq.size()), 8'h01, "rx count paused");
		chk_byte(rxq[0], hs[1], "rx byte paused");
	endtask : pause_test

	task automatic guard_test();
		logic [20:0] a;
		logic        in_r, g, b;
		int          sz;
		for (int w = 0; w < 2; w++) for (int p = 0; p < 8; p++) for (int k = 0; k < 2; k++) begin
			// probe the lowest protected byte and the one just below it
			sz = (p == 0) ? 0 : (p >= 6) ? 32 : (1 << (p - 1));
			a = 21'((32 - sz) << 16) - 21'(k);
			in_r = (sz != 0) && (int'(a[20:16]) >= 32 - sz);
			@(posedge clk) #2 wp_n = w[0];
			bp = p[2:0];
			repeat (4) @(posedge clk);
			#2 wr_req = 1'b1;
			wr_addr = a;
			@(posedge clk) #2 wr_req = 1'b0;
			g = wr_grant;
			b = wr_block;
			@(posedge clk) #2 g = g | wr_grant;
			b = b | wr_block;
			chk_bit(b, !w[0] && in_r, "block");
			chk_bit(g, !(!w[0] && in_r), "grant");
		end
	endtask : guard_test

	// =====================================================
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		wp_n = 1'b1;
		wr_req = 1'b0;
		op_busy = 1'b0;
		wr_addr = 21'h000000;
		bp = 3'h0;
		txt = '{8'ha5, 8'h3c, 8'hf0, 8'h81};
		hs = '{8'h96, 8'h5a, 8'h0f, 8'hc3};
		repeat (6) @(posedge clk);
		chk_bit(so_oe, 1'b0, "oe in reset");
		chk_bit(standby, 1'b1, "standby in reset");
		#2 rst = 1'b0;
		frame_test(1'b0, 3);
		frame_test(1'b1, 2);
		standby_test();
		pause_test();
		guard_test();
		conclude();
	end

	initial begin
		#400000;
		num_errors++;
		conclude();
	end
endmodule : sfp_pin_if_tb_top
`default_nettype wire
